//--- hw/dct_defines.vh
// register map, field layout and constants of the dual counter/timer block
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH

// bank selection
`define DCT_BANK_NORMAL      4'h0
`define DCT_BANK_TIMERS      4'hD
`define DCT_LOW_PAGE         4'h0

// bank D offsets
`define DCT_OFF_BYTE_CTRL    4'h0
`define DCT_OFF_SHARED_CTRL  4'h1
`define DCT_OFF_WORD_CTRL    4'h2
`define DCT_OFF_BYTE_LOW     4'h4
`define DCT_OFF_BYTE_HIGH    4'h5
`define DCT_OFF_RELOAD_LOW   4'h6
`define DCT_OFF_RELOAD_HIGH  4'h7
`define DCT_OFF_CAPT_LOW     4'h8
`define DCT_OFF_CAPT_HIGH    4'h9
`define DCT_OFF_INT_STATUS   4'hA
`define DCT_OFF_INT_MASK     4'hB

// counter control fields (byte and word)
`define DCT_RUN_BIT          7
`define DCT_SINGLE_BIT       6
`define DCT_TIMEOUT_BIT      5
`define DCT_PRESC_HI         4
`define DCT_PRESC_LO         3
`define DCT_MASK_BIT         2
`define DCT_ROUTE_BIT        1

// shared control fields
`define DCT_PP_HI            3
`define DCT_PP_LO            2
`define DCT_DEMOD_BIT        1
`define DCT_EDGE_BIT         0
`define DCT_PP_ON            2'b11

// interrupt status bits
`define DCT_IS_BYTE_TO       0
`define DCT_IS_WORD_TO       1
`define DCT_IS_CAPTURE       2

// prescale masks, reset values and count steps
`define DCT_DIV1             3'h0
`define DCT_DIV2             3'h1
`define DCT_DIV4             3'h3
`define DCT_DIV8             3'h7
`define DCT_ZERO8            8'h00
`define DCT_ZERO16           16'h0000
`define DCT_ZERO3            3'h0
`define DCT_ONE3             3'h1
`define DCT_ONE8             8'h01
`define DCT_ONE16            16'h0001

`endif

//--- hw/dct_timers.v
// eight-bit and sixteen-bit counter/timer pair in expanded bank D
//
// Contract
// [RQ1] low pointer nibble selects bank; zero normal
// [RQ2] all timer registers live in bank D
// [RQ3] capture bytes at 09h/08h, writes ignored
// [RQ4] word reload hold bytes at 07h/06h
// [RQ5] byte high/low level holds at 05h/04h
// [RQ6] bit 7 starts/stops byte counter, reads run
// [RQ7] bit 6: modulo-N reload or single pass
// [RQ8] bit 5 set at every terminal count
// [RQ9] writing one clears time-out flag
// [RQ10] bits 4:3 prescale by 1,2,4,8
// [RQ11] capture interrupt only while capture mask set
// [RQ12] word time-out interrupt only while masked in
// [RQ13] control bit routes port or counter to pin
// [RQ14] demod edge option: all edges or first only
// [RQ15] software stops, sets single pass, then enables
// [RQ16] ping-pong alternates enables between both counters
// [RQ17] timers supply two interrupt requests
// [RQ18] both capture bytes update in one cycle
`include "dct_defines.vh"

module dct_timers (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire [7:0] register_pointer,
    // demodulation input and shared pin
    input  wire       demod_in,
    input  wire       port_out_value,
    output reg        pin_out,
    output reg        byte_counter_out,
    // interrupt requests
    output reg        capture_request,
    output reg        timeout_request,
    output reg        irq
);

    // control and hold registers
    reg  [7:0]  byte_counter_control;
    reg  [7:0]  shared_counter_control;
    reg  [7:0]  word_counter_control;
    reg  [7:0]  byte_counter_low_hold;
    reg  [7:0]  byte_counter_high_hold;
    reg  [7:0]  word_counter_reload_low;
    reg  [7:0]  word_counter_reload_high;
    reg  [7:0]  capture_low_byte;
    reg  [7:0]  capture_high_byte;
    reg  [2:0]  int_status;
    reg  [2:0]  int_mask;
    // counter state
    reg  [2:0]  presc_count;
    reg  [7:0]  byte_count;
    reg  [15:0] word_count;
    reg         byte_level;
    reg         word_out;
    reg         byte_run_d;
    reg         word_run_d;
    reg         demod_d;
    reg         edge_seen;

    // decode: bank D only swaps in the lowest sixteen addresses
    wire bank_hit = (register_pointer[3:0] == `DCT_BANK_TIMERS) &&
                    (reg_addr[7:4] == `DCT_LOW_PAGE);                    // [RQ1] [RQ2]
    wire [3:0] off = reg_addr[3:0];
    wire wr_hit = reg_wr && bank_hit;

    function presc_tick;
        input [1:0] sel;
        input [2:0] cnt;
        reg   [2:0] m;
        begin
            if (sel == 2'b00) begin
                m = `DCT_DIV1;
            end else if (sel == 2'b01) begin
                m = `DCT_DIV2;
            end else if (sel == 2'b10) begin
                m = `DCT_DIV4;
            end else begin
                m = `DCT_DIV8;
            end
            presc_tick = ((cnt & m) == m);                               // [RQ10]
        end
    endfunction

    wire byte_run  = byte_counter_control[`DCT_RUN_BIT];
    wire word_run  = word_counter_control[`DCT_RUN_BIT];
    wire ping_pong = (shared_counter_control[`DCT_PP_HI:`DCT_PP_LO] == `DCT_PP_ON);
    wire byte_tick = byte_run &&
        presc_tick(byte_counter_control[`DCT_PRESC_HI:`DCT_PRESC_LO], presc_count);
    wire word_tick = word_run &&
        presc_tick(word_counter_control[`DCT_PRESC_HI:`DCT_PRESC_LO], presc_count);
    wire byte_start = byte_run && !byte_run_d;
    wire word_start = word_run && !word_run_d;

    // terminal counts: counters go down and end when zero is reached
    wire byte_term = byte_tick && !byte_start && (byte_count == `DCT_ZERO8);
    wire word_term = word_tick && !word_start && (word_count == `DCT_ZERO16);

    // demodulation edges; edge option 1 keeps only the first after start
    wire demod_on   = shared_counter_control[`DCT_DEMOD_BIT];
    wire demod_edge = demod_on && word_run && (demod_in != demod_d);
    wire capture_ev = demod_edge &&
        !(shared_counter_control[`DCT_EDGE_BIT] && edge_seen);           // [RQ14]

    wire [15:0] reload_word = {word_counter_reload_high, word_counter_reload_low};

    // free prescale divider shared by both counters
    always @(posedge clock) begin
        if (rst) begin
            presc_count <= `DCT_ZERO3;
        end else begin
            presc_count <= presc_count + `DCT_ONE3;
        end
    end

    // hold, reload and shared control registers
    always @(posedge clock) begin
        if (rst) begin
            byte_counter_low_hold    <= `DCT_ZERO8;
            byte_counter_high_hold   <= `DCT_ZERO8;
            word_counter_reload_low  <= `DCT_ZERO8;
            word_counter_reload_high <= `DCT_ZERO8;
            shared_counter_control   <= `DCT_ZERO8;
            int_mask                 <= `DCT_ZERO3;
        end else if (wr_hit) begin
            if (off == `DCT_OFF_BYTE_LOW) begin
                byte_counter_low_hold <= reg_wdata;                      // [RQ5]
            end else if (off == `DCT_OFF_BYTE_HIGH) begin
                byte_counter_high_hold <= reg_wdata;                     // [RQ5]
            end else if (off == `DCT_OFF_RELOAD_LOW) begin
                word_counter_reload_low <= reg_wdata;                    // [RQ4]
            end else if (off == `DCT_OFF_RELOAD_HIGH) begin
                word_counter_reload_high <= reg_wdata;                   // [RQ4]
            end else if (off == `DCT_OFF_SHARED_CTRL) begin
                shared_counter_control <= reg_wdata;
            end else if (off == `DCT_OFF_INT_MASK) begin
                int_mask <= reg_wdata[2:0];
            end
        end
    end

    // byte counter control: software write first, hardware events override
    always @(posedge clock) begin
        if (rst) begin
            byte_counter_control <= `DCT_ZERO8;                          // [RQ6]
        end else begin
            if (wr_hit && off == `DCT_OFF_BYTE_CTRL) begin
                byte_counter_control[`DCT_RUN_BIT] <= reg_wdata[`DCT_RUN_BIT]; // [RQ6]
                byte_counter_control[`DCT_SINGLE_BIT] <= reg_wdata[`DCT_SINGLE_BIT]; // [RQ7]
                byte_counter_control[`DCT_PRESC_HI:`DCT_PRESC_LO] <=
                    reg_wdata[`DCT_PRESC_HI:`DCT_PRESC_LO];              // [RQ10]
                byte_counter_control[`DCT_MASK_BIT:0] <= reg_wdata[`DCT_MASK_BIT:0];
                if (reg_wdata[`DCT_TIMEOUT_BIT]) begin
                    byte_counter_control[`DCT_TIMEOUT_BIT] <= 1'b0;      // [RQ9]
                end
            end
            // a set arriving with the clear wins
            if (byte_term) begin
                byte_counter_control[`DCT_TIMEOUT_BIT] <= 1'b1;          // [RQ8]
                if (byte_counter_control[`DCT_SINGLE_BIT] && !byte_level) begin
                    byte_counter_control[`DCT_RUN_BIT] <= 1'b0;          // [RQ7] [RQ16]
                end
            end
            if (ping_pong && word_term) begin
                byte_counter_control[`DCT_RUN_BIT] <= 1'b1;              // [RQ16]
            end
        end
    end

    // word counter control, mirror of the byte counter
    always @(posedge clock) begin
        if (rst) begin
            word_counter_control <= `DCT_ZERO8;
        end else begin
            if (wr_hit && off == `DCT_OFF_WORD_CTRL) begin
                word_counter_control[`DCT_RUN_BIT] <= reg_wdata[`DCT_RUN_BIT];
                word_counter_control[`DCT_SINGLE_BIT] <= reg_wdata[`DCT_SINGLE_BIT]; // [RQ7]
                word_counter_control[`DCT_PRESC_HI:0] <= reg_wdata[`DCT_PRESC_HI:0]; // [RQ10]
                if (reg_wdata[`DCT_TIMEOUT_BIT]) begin
                    word_counter_control[`DCT_TIMEOUT_BIT] <= 1'b0;      // [RQ9]
                end
            end
            if (word_term) begin
                word_counter_control[`DCT_TIMEOUT_BIT] <= 1'b1;          // [RQ8]
                if (word_counter_control[`DCT_SINGLE_BIT]) begin
                    word_counter_control[`DCT_RUN_BIT] <= 1'b0;          // [RQ7] [RQ16]
                end
            end
            // ping-pong: the byte counter ending a full pass hands over
            if (ping_pong && byte_term && !byte_level) begin
                word_counter_control[`DCT_RUN_BIT] <= 1'b1;              // [RQ16]
            end
        end
    end

    // byte counter: high level period, then low level period
    always @(posedge clock) begin
        if (rst) begin
            byte_count <= `DCT_ZERO8;
            byte_level <= 1'b0;
            byte_run_d <= 1'b0;
        end else begin
            byte_run_d <= byte_run;
            if (byte_start) begin
                byte_count <= byte_counter_high_hold;
                byte_level <= 1'b1;
            end else if (byte_term) begin
                byte_level <= !byte_level;
                if (byte_level) begin
                    byte_count <= byte_counter_low_hold;
                end else begin
                    byte_count <= byte_counter_high_hold;
                end
            end else if (byte_tick) begin
                byte_count <= byte_count - `DCT_ONE8;
            end
        end
    end

    // word counter with modulo reload, demodulation capture and reload
    always @(posedge clock) begin
        if (rst) begin
            word_count        <= `DCT_ZERO16;
            word_out          <= 1'b0;
            word_run_d        <= 1'b0;
            demod_d           <= 1'b0;
            edge_seen         <= 1'b0;
            capture_low_byte  <= `DCT_ZERO8;
            capture_high_byte <= `DCT_ZERO8;
        end else begin
            word_run_d <= word_run;
            demod_d    <= demod_in;
            if (word_start) begin
                word_count <= reload_word;
                edge_seen  <= 1'b0;
            end else if (capture_ev) begin
                // one write of both halves keeps the pair coherent
                capture_high_byte <= word_count[15:8];                   // [RQ3] [RQ18]
                capture_low_byte  <= word_count[7:0];                    // [RQ3] [RQ18]
                word_count        <= reload_word;                        // [RQ14]
                edge_seen         <= 1'b1;
            end else if (word_term) begin
                word_out   <= !word_out;
                word_count <= reload_word;
            end else if (word_tick) begin
                word_count <= word_count - `DCT_ONE16;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always @(posedge clock) begin
        if (rst) begin
            int_status <= `DCT_ZERO3;
        end else begin
            if (wr_hit && off == `DCT_OFF_INT_STATUS) begin
                int_status <= (int_status & ~reg_wdata[2:0]) |
                    {capture_ev, word_term, byte_term};
            end else begin
                int_status <= int_status | {capture_ev, word_term, byte_term};
            end
        end
    end

    // outputs, all from flip-flops
    always @(posedge clock) begin
        if (rst) begin
            pin_out          <= 1'b0;
            byte_counter_out <= 1'b0;
            capture_request  <= 1'b0;
            timeout_request  <= 1'b0;
            irq              <= 1'b0;
        end else begin
            if (word_counter_control[`DCT_ROUTE_BIT]) begin
                pin_out <= word_out;                                     // [RQ13]
            end else begin
                pin_out <= port_out_value;                               // [RQ13]
            end
            byte_counter_out <= byte_level && byte_run;
            capture_request  <= capture_ev && byte_counter_control[`DCT_MASK_BIT]; // [RQ11] [RQ17]
            timeout_request  <= word_term && word_counter_control[`DCT_MASK_BIT];  // [RQ12] [RQ17]
            irq              <= |(int_status & int_mask);
        end
    end

    // read data one cycle after the strobe; anything else reads zero
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= `DCT_ZERO8;
        end else if (reg_rd && bank_hit) begin
            if (off == `DCT_OFF_BYTE_CTRL) begin
                reg_rdata <= byte_counter_control;                       // [RQ6]
            end else if (off == `DCT_OFF_SHARED_CTRL) begin
                reg_rdata <= shared_counter_control;
            end else if (off == `DCT_OFF_WORD_CTRL) begin
                reg_rdata <= word_counter_control;
            end else if (off == `DCT_OFF_BYTE_LOW) begin
                reg_rdata <= byte_counter_low_hold;
            end else if (off == `DCT_OFF_BYTE_HIGH) begin
                reg_rdata <= byte_counter_high_hold;
            end else if (off == `DCT_OFF_RELOAD_LOW) begin
                reg_rdata <= word_counter_reload_low;
            end else if (off == `DCT_OFF_RELOAD_HIGH) begin
                reg_rdata <= word_counter_reload_high;
            end else if (off == `DCT_OFF_CAPT_LOW) begin
                reg_rdata <= capture_low_byte;                           // [RQ3]
            end else if (off == `DCT_OFF_CAPT_HIGH) begin
                reg_rdata <= capture_high_byte;                          // [RQ3]
            end else if (off == `DCT_OFF_INT_STATUS) begin
                reg_rdata <= {5'b0_0000, int_status};
            end else if (off == `DCT_OFF_INT_MASK) begin
                reg_rdata <= {5'b0_0000, int_mask};
            end else begin
                reg_rdata <= `DCT_ZERO8;
            end
        end else begin
            reg_rdata <= `DCT_ZERO8;
        end
    end

endmodule

//--- tb/dct_timers_sva.sv
// concurrent checks and cover points on the ports of the counter/timer block
module dct_timers_sva (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] register_pointer,
    // pins and requests
    input wire logic       demod_in,
    input wire logic       port_out_value,
    input wire logic       pin_out,
    input wire logic       byte_counter_out,
    input wire logic       capture_request,
    input wire logic       timeout_request,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       route;
    logic       tmask;
    logic       cmask;
    logic       demod_q;
    logic [2:0] since_edge;
    wire        hit = reg_wr && register_pointer[3:0] == 4'hD && reg_addr[7:4] == 4'h0;

    // shadow of the route and mask bits, so pin and request checks know the mode
    always @(posedge clock) begin
        demod_q <= demod_in;
        if (rst) begin
            route <= 1'b0;
            tmask <= 1'b0;
            cmask <= 1'b0;
            since_edge <= 3'h7;
        end else begin
            if (hit && reg_addr[3:0] == 4'h2) begin
                route <= reg_wdata[1];
                tmask <= reg_wdata[2];
            end
            if (hit && reg_addr[3:0] == 4'h0) cmask <= reg_wdata[2];
            if (demod_in != demod_q) since_edge <= 3'h0;
            else if (since_edge != 3'h7) since_edge <= since_edge + 3'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");
    property p_off_bank;
        reg_rd && (register_pointer[3:0] != 4'hD || reg_addr[7:4] != 4'h0) |=> reg_rdata == 8'h00;
    endproperty
    a_off_bank: assert property (p_off_bank)
        else $error("timer register visible outside bank D");
    // the bench leaves one idle cycle between a write and the read that follows it
    property p_hold_back;
        (hit && reg_addr[3:2] == 2'b01) ##2 (reg_rd && reg_addr == $past(reg_addr, 2)
            && register_pointer[3:0] == 4'hD) |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_hold_back: assert property (p_hold_back)
        else $error("hold register lost written value");
    // irq trails the status and mask registers by one cycle, so look two back
    property p_irq_fall;
        $fell(irq) |-> $past(reg_wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a register write");
    property p_pin_port;
        !$past(rst) && !route && !$past(route) |-> pin_out == $past(port_out_value);
    endproperty
    a_pin_port: assert property (p_pin_port)
        else $error("pin does not follow port value");
    property p_to_masked;
        !tmask && !$past(tmask) && !$past(tmask, 2) |-> !timeout_request;
    endproperty
    a_to_masked: assert property (p_to_masked)
        else $error("time-out request while masked");
    property p_cap_masked;
        !cmask && !$past(cmask) && !$past(cmask, 2) |-> !capture_request;
    endproperty
    a_cap_masked: assert property (p_cap_masked)
        else $error("capture request while masked");
    property p_cap_edge;
        capture_request |-> since_edge <= 3'h5;
    endproperty
    a_cap_edge: assert property (p_cap_edge)
        else $error("capture request without a recent edge");

    // main scenarios reached
    c_timeout: cover property (timeout_request);
    c_capture: cover property (capture_request);
    c_irq: cover property ($rose(irq));
endmodule

bind dct_timers dct_timers_sva u_sva (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .register_pointer(register_pointer), .demod_in(demod_in), .port_out_value(port_out_value),
    .pin_out(pin_out), .byte_counter_out(byte_counter_out), .capture_request(capture_request),
    .timeout_request(timeout_request), .irq(irq));

//--- tb/dct_timers_tb.sv
// self-checking bench for the counter/timer block
module dct_timers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic       demod_in;
    logic       port_out_value;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] register_pointer;
    wire  [7:0] reg_rdata;
    wire        pin_out;
    wire        byte_counter_out;
    wire        capture_request;
    wire        timeout_request;
    wire        irq;
    logic       pin_q;
    int         err_count = 0;
    int         num_checks = 0;
    int         cyc = 0;
    int         to_n, cap_n, pin_n, hi_n, k, d;

    dct_timers dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .register_pointer(register_pointer), .demod_in(demod_in),
        .port_out_value(port_out_value), .pin_out(pin_out),
        .byte_counter_out(byte_counter_out), .capture_request(capture_request),
        .timeout_request(timeout_request), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // event counters; a hang stops the run well past the expected length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        pin_q <= pin_out;
        if (timeout_request === 1'b1) to_n <= to_n + 1;
        if (capture_request === 1'b1) cap_n <= cap_n + 1;
        if (byte_counter_out === 1'b1) hi_n <= hi_n + 1;
        if (pin_out !== pin_q) pin_n <= pin_n + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // every access ends 1 ns after an edge so counter resets never race
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata & m}, {8'h00, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic toggle2;
        repeat (2) begin
            @(posedge clock) demod_in <= ~demod_in;
            idle(4);
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {rst, reg_wr, reg_rd, demod_in, port_out_value} = 5'b10000;
        {reg_addr, reg_wdata, register_pointer} = {16'h0000, 8'h0D};
        {to_n, cap_n, pin_n, hi_n} = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        // reset values, hold registers, read-only capture and bank selection
        for (int a = 0; a < 10; a++) rd(a[7:0], 8'hFF, 8'h00);
        // each hold byte read straight back, so the read-back check sees the pair
        for (int a = 4; a < 8; a++) begin
            wr(a[7:0], {a[3:0], 4'hA});
            rd(a[7:0], 8'hFF, {a[3:0], 4'hA});
        end
        wr(8'h08, 8'hFF);
        wr(8'h09, 8'hFF);
        rd(8'h08, 8'hFF, 8'h00);
        rd(8'h09, 8'hFF, 8'h00);
        @(posedge clock) register_pointer <= 8'h00;
        rd(8'h04, 8'hFF, 8'h00);
        @(posedge clock) register_pointer <= 8'h05;
        rd(8'h04, 8'hFF, 8'h00);
        @(posedge clock) register_pointer <= 8'h7D;
        rd(8'h04, 8'hFF, 8'h4A);
        rd(8'h14, 8'hFF, 8'h00);
        // byte counter single pass, flag and interrupt
        {to_n, cap_n, pin_n, hi_n} = '0;
        wr(8'h04, 8'h02);
        wr(8'h05, 8'h02);
        wr(8'h06, 8'h07);
        wr(8'h07, 8'h00);
        wr(8'h0B, 8'h01);
        wr(8'h00, 8'hC0);
        idle(40);
        rd(8'h00, 8'hE0, 8'h60);
        check(hi_n > 0, 16'h0001);
        check(irq, 16'h0001);
        wr(8'h0B, 8'h00);
        idle(1);
        check(irq, 16'h0000);
        wr(8'h0B, 8'h01);
        idle(1);
        check(irq, 16'h0001);
        wr(8'h0A, 8'h01);
        idle(1);
        check(irq, 16'h0000);
        wr(8'h00, 8'h40);
        rd(8'h00, 8'h20, 8'h20);
        wr(8'h00, 8'h60);
        rd(8'h00, 8'h20, 8'h00);
        // prescale choices timed on a single pass of the word counter
        for (int p = 0; p < 4; p++) begin
            d = 1 << p;
            wr(8'h02, {3'b110, p[1:0], 3'b100});
            k = 0;
            while (timeout_request !== 1'b1 && k < 100) begin
                idle(1);
                k++;
            end
            check((k >= 7 * d + 2) && (k <= 9 * d + 4), 16'h0001);
            rd(8'h02, 8'hA0, 8'h20);
            wr(8'h02, 8'h20);
        end
        // modulo reload with the pin routed to the counter, then masked
        to_n = 0;
        pin_n = 0;
        wr(8'h02, 8'h86);
        idle(80);
        check((to_n >= 9) && (to_n <= 10), 16'h0001);
        check(pin_n > 0, 16'h0001);
        wr(8'h02, 8'h80);
        to_n = 0;
        idle(40);
        check(to_n[15:0], 16'h0000);
        @(posedge clock) port_out_value <= 1'b1;
        idle(2);
        check(pin_out, 16'h0001);
        wr(8'h02, 8'h00);
        // demodulation capture: every edge, first edge only, masked
        wr(8'h06, 8'h20);
        wr(8'h07, 8'h01);
        wr(8'h00, 8'h04);
        wr(8'h01, 8'h02);
        wr(8'h02, 8'h80);
        cap_n = 0;
        toggle2();
        check(cap_n[15:0], 16'h0002);
        rd(8'h09, 8'hFF, 8'h01);
        wr(8'h02, 8'h00);
        wr(8'h01, 8'h03);
        wr(8'h02, 8'h80);
        cap_n = 0;
        toggle2();
        check(cap_n[15:0], 16'h0001);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h00);
        cap_n = 0;
        toggle2();
        check(cap_n[15:0], 16'h0000);
        wr(8'h02, 8'h00);
        wr(8'h01, 8'h00);
        // ping-pong alternation between the two counters
        wr(8'h06, 8'h07);
        wr(8'h07, 8'h00);
        wr(8'h00, 8'h40);
        wr(8'h02, 8'h44);
        wr(8'h01, 8'h0C);
        to_n = 0;
        wr(8'h00, 8'hC0);
        idle(300);
        check(to_n >= 2, 16'h0001);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h02, 8'h00);
        summarize();
    end
endmodule
